/* File: inc/pll_ref_cfg.svh */
// Register map, field positions, reset values and codes of the PLL reference configuration block.
`ifndef PLL_REF_CFG_SVH
`define PLL_REF_CFG_SVH

`define ADDR_W 8
`define DATA_W 32
`define IDX_W 4
`define REF_DIV_W 8
`define VCO_W 2
`define FILT_W 2

`define CLKSEL_IDX 4'h0
`define CLOCK_WRITE_PROTECT_IDX 4'h1
`define PLLCFG_IDX 4'h2
`define STATUS_IDX 4'h3
`define REFERENCE_DIVIDER_VALUE_IDX 4'h5

`define SEL_PLL_BIT 0
`define SEL_EXTERNAL_OSC_ENABLE_BIT 1
`define CLOCK_WRITE_PROTECT_BIT 0
`define CFG_VCO_LSB 0
`define CFG_FILT_LSB 4
`define STAT_LOCK_BIT 0
`define STAT_OSC_BIT 1

`define REFERENCE_DIVIDER_VALUE_RST 8'h00
`define VCO_RST 2'h0
`define FILT_RST 2'h0
`define FILT_FIXED_1_2MHZ 2'h0
`define VCO_32_48MHZ 2'h0
`define VCO_48_64MHZ 2'h1

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: inc/pll_ref_pkg.sv */
// Types shared by the PLL reference configuration modules.
package pll_ref_pkg;
`include "pll_ref_cfg.svh"

  typedef logic [`REF_DIV_W-1:0] ref_div_t;
  typedef logic [`VCO_W-1:0] vco_code_t;
  typedef logic [`FILT_W-1:0] filt_code_t;
  typedef logic [1:0] axi_resp_t;
  typedef enum {WR_COLLECT, WR_RESPOND} wr_state_t;

endpackage

/* File: inc/ref_div_if.sv */
// Link between the configuration logic and the reference divider.
`timescale 1ns/1ps
interface ref_div_if;
  logic [7:0] divisor;
  logic osc_edge;
  logic restart;
  logic tick;
  modport ctrl (output divisor, output osc_edge, output restart, input tick);
  modport div (input divisor, input osc_edge, input restart, output tick);
endinterface

/* File: src/ref_divider.sv */
// Divides oscillator edges by the reference divider value plus one.
`timescale 1ns/1ps
module ref_divider
  import pll_ref_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  ref_div_if.div link
);

  ref_div_t count_reg;
  ref_div_t count_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    count_next = count_reg;
    tick_next = 1'b0;
    if (link.restart) begin
      count_next = `REFERENCE_DIVIDER_VALUE_RST;
    end else if (link.osc_edge) begin
      if (count_reg >= link.divisor) begin
        count_next = `REFERENCE_DIVIDER_VALUE_RST;
        tick_next = 1'b1;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= `REFERENCE_DIVIDER_VALUE_RST;
      tick_reg <= 1'b0;
    end else if (ce) begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign link.tick = tick_reg;

endmodule

/* File: src/pll_reference_config.sv */
// PLL reference selection, divider and VCO/filter range configuration behind an AXI4-Lite slave.
`timescale 1ns/1ps
module pll_reference_config
  import pll_ref_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_clk_in,
  input wire logic internal_rc_1mhz,
  input wire logic pll_lock_in,
  input wire logic osc_stable_in,
  output logic pll_reference_clock,
  output logic [1:0] vco_range_code,
  output logic [1:0] loop_filter_setting,
  output logic external_osc_enable,
  output logic pll_restart
);

  // Byte address of a register is four times its index.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [3:0] idx);
    reg_hit = (addr == {2'h0, idx, 2'h0});
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = reg_hit(addr, `CLKSEL_IDX) || reg_hit(addr, `CLOCK_WRITE_PROTECT_IDX) || reg_hit(addr, `PLLCFG_IDX) ||
                reg_hit(addr, `STATUS_IDX) || reg_hit(addr, `REFERENCE_DIVIDER_VALUE_IDX);
  endfunction

  // Pin inputs pass two flip-flops; edges are taken only after the second.
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] rise;
  assign rise = sync2_reg & ~sync3_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
    end else if (ce) begin
      sync1_reg <= {osc_stable_in, pll_lock_in, internal_rc_1mhz, osc_clk_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  ref_div_if div_link ();

  ref_divider u_divider (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .link(div_link)
  );

  wr_state_t wr_state_reg, wr_state_next;
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  axi_resp_t bresp_reg, bresp_next;
  logic bvalid_reg, bvalid_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  axi_resp_t rresp_reg, rresp_next;
  logic pll_sel_reg, pll_sel_next;
  logic external_osc_enable_reg, external_osc_enable_next;
  logic protect_reg, protect_next;
  vco_code_t vco_reg, vco_next;
  filt_code_t filt_reg, filt_next;
  ref_div_t reference_divider_value_reg, reference_divider_value_next;
  logic lock_flag_reg, lock_flag_next;
  logic osc_flag_reg, osc_flag_next;
  logic restart_reg, restart_next;
  logic ref_clk_reg, ref_clk_next;
  vco_code_t vco_out_reg;
  filt_code_t filt_out_reg, filt_out_next;
  logic div_clear;

  assign div_link.divisor = reference_divider_value_reg;
  assign div_link.osc_edge = rise[0];
  assign div_link.restart = restart_reg;

  always_comb begin
    wr_state_next = wr_state_reg;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bresp_next = bresp_reg;
    pll_sel_next = pll_sel_reg;
    external_osc_enable_next = external_osc_enable_reg;
    protect_next = protect_reg;
    vco_next = vco_reg;
    filt_next = filt_reg;
    reference_divider_value_next = reference_divider_value_reg;
    div_clear = 1'b0;
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata[7:0];
      wstrb0_next = s_axi_wstrb[0];
    end
    case (wr_state_reg)
      WR_COLLECT: begin
        if (aw_held_reg && w_held_reg) begin
          aw_held_next = 1'b0;
          w_held_next = 1'b0;
          wr_state_next = WR_RESPOND;
          bresp_next = is_mapped(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
          if (wstrb0_reg) begin
            if (reg_hit(awaddr_reg, `CLKSEL_IDX)) begin
              pll_sel_next = wdata_reg[`SEL_PLL_BIT];
              external_osc_enable_next = wdata_reg[`SEL_EXTERNAL_OSC_ENABLE_BIT];
            end
            if (reg_hit(awaddr_reg, `CLOCK_WRITE_PROTECT_IDX)) begin
              protect_next = wdata_reg[`CLOCK_WRITE_PROTECT_BIT];
            end
            if (reg_hit(awaddr_reg, `PLLCFG_IDX)) begin
              // Reserved range codes are refused so the PLL never sees an undefined range.
              if (wdata_reg[`CFG_VCO_LSB +: `VCO_W] == `VCO_32_48MHZ ||
                  wdata_reg[`CFG_VCO_LSB +: `VCO_W] == `VCO_48_64MHZ) begin
                vco_next = wdata_reg[`CFG_VCO_LSB +: `VCO_W];
              end
              filt_next = wdata_reg[`CFG_FILT_LSB +: `FILT_W];
            end
            if (reg_hit(awaddr_reg, `REFERENCE_DIVIDER_VALUE_IDX) && !protect_reg && pll_sel_reg) begin
              reference_divider_value_next = wdata_reg;
              div_clear = 1'b1;
            end
          end
        end
      end
      WR_RESPOND: begin
        if (s_axi_bready) begin
          wr_state_next = WR_COLLECT;
        end
      end
      default: begin
        wr_state_next = WR_COLLECT;
      end
    endcase
    awready_next = !aw_held_next && (wr_state_next == WR_COLLECT);
    wready_next = !w_held_next && (wr_state_next == WR_COLLECT);
    bvalid_next = (wr_state_next == WR_RESPOND);
    // A status event in the clearing cycle is kept: set wins over clear.
    lock_flag_next = (lock_flag_reg && !div_clear) || rise[2];
    osc_flag_next = (osc_flag_reg && !div_clear) || rise[3];
    restart_next = div_clear;
    ref_clk_next = external_osc_enable_reg ? div_link.tick : rise[1];
    filt_out_next = external_osc_enable_reg ? filt_reg : `FILT_FIXED_1_2MHZ;
  end

  always_comb begin
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      rdata_next = 32'h0000_0000;
      if (reg_hit(s_axi_araddr, `CLKSEL_IDX)) begin
        rdata_next[`SEL_PLL_BIT] = pll_sel_reg;
        rdata_next[`SEL_EXTERNAL_OSC_ENABLE_BIT] = external_osc_enable_reg;
      end
      if (reg_hit(s_axi_araddr, `CLOCK_WRITE_PROTECT_IDX)) begin
        rdata_next[`CLOCK_WRITE_PROTECT_BIT] = protect_reg;
      end
      if (reg_hit(s_axi_araddr, `PLLCFG_IDX)) begin
        rdata_next[`CFG_VCO_LSB +: `VCO_W] = vco_reg;
        rdata_next[`CFG_FILT_LSB +: `FILT_W] = filt_reg;
      end
      if (reg_hit(s_axi_araddr, `STATUS_IDX)) begin
        rdata_next[`STAT_LOCK_BIT] = lock_flag_reg;
        rdata_next[`STAT_OSC_BIT] = osc_flag_reg;
      end
      if (reg_hit(s_axi_araddr, `REFERENCE_DIVIDER_VALUE_IDX)) begin
        rdata_next[`REF_DIV_W-1:0] = reference_divider_value_reg;
      end
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= WR_COLLECT;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      bvalid_reg <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
      pll_sel_reg <= 1'b0;
      external_osc_enable_reg <= 1'b0;
      protect_reg <= 1'b0;
      vco_reg <= `VCO_RST;
      filt_reg <= `FILT_RST;
      reference_divider_value_reg <= `REFERENCE_DIVIDER_VALUE_RST;
      lock_flag_reg <= 1'b0;
      osc_flag_reg <= 1'b0;
      restart_reg <= 1'b0;
      ref_clk_reg <= 1'b0;
      vco_out_reg <= `VCO_RST;
      filt_out_reg <= `FILT_FIXED_1_2MHZ;
    end else if (ce) begin
      wr_state_reg <= wr_state_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bresp_reg <= bresp_next;
      bvalid_reg <= bvalid_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      pll_sel_reg <= pll_sel_next;
      external_osc_enable_reg <= external_osc_enable_next;
      protect_reg <= protect_next;
      vco_reg <= vco_next;
      filt_reg <= filt_next;
      reference_divider_value_reg <= reference_divider_value_next;
      lock_flag_reg <= lock_flag_next;
      osc_flag_reg <= osc_flag_next;
      restart_reg <= restart_next;
      ref_clk_reg <= ref_clk_next;
      vco_out_reg <= vco_reg;
      filt_out_reg <= filt_out_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign pll_reference_clock = ref_clk_reg;
  assign vco_range_code = vco_out_reg;
  assign loop_filter_setting = filt_out_reg;
  assign external_osc_enable = external_osc_enable_reg;
  assign pll_restart = restart_reg;

endmodule

/* File: dv/pll_reference_config_checker.sv */
// Concurrent checks on the ports of the PLL reference configuration block.
`timescale 1ns/1ps
`include "pll_ref_cfg.svh"
module pll_reference_config_checker
  import pll_ref_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic pll_restart,
  input wire logic pll_reference_clock,
  input wire logic [1:0] vco_range_code,
  input wire logic [1:0] loop_filter_setting,
  input wire logic external_osc_enable
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid) else $error("read data late");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
  a_ready_back: assert property ($fell(s_axi_bvalid) |-> ##[0:1] (s_axi_awready && s_axi_wready))
    else $error("write readies did not return");
  a_restart_once: assert property (pll_restart |=> !pll_restart) else $error("restart longer than a cycle");
  // Synced oscillator edges are at least two cycles apart, so reference pulses from one source never touch while ce stays high.
  a_ref_single: assert property (pll_reference_clock |=> !pll_reference_clock) else $error("reference pulse too wide");
  a_vco_legal: assert property (vco_range_code inside {`VCO_32_48MHZ, `VCO_48_64MHZ}) else $error("reserved vco code");
  a_filter_fixed: assert property (!external_osc_enable && $past(!external_osc_enable)
    |-> loop_filter_setting == `FILT_FIXED_1_2MHZ) else $error("filter moved on rc reference");
endmodule
bind pll_reference_config pll_reference_config_checker pll_reference_config_checker_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .pll_restart(pll_restart),
  .pll_reference_clock(pll_reference_clock), .vco_range_code(vco_range_code),
  .loop_filter_setting(loop_filter_setting), .external_osc_enable(external_osc_enable));

/* File: dv/pll_reference_config_bench.sv */
// Self-checking testbench for the PLL reference configuration block.
`timescale 1ns/1ps
`include "pll_ref_cfg.svh"
module pll_reference_config_bench
  import pll_ref_pkg::*;
;
  logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, vco_range_code, loop_filter_setting;
  logic osc_clk_in, internal_rc_1mhz, pll_lock_in, osc_stable_in;
  logic pll_reference_clock, external_osc_enable, pll_restart;
  int n_fail, comparisons, cycles, pulses, restarts;

  pll_reference_config pll_reference_config_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .osc_clk_in(osc_clk_in),
    .internal_rc_1mhz(internal_rc_1mhz), .pll_lock_in(pll_lock_in), .osc_stable_in(osc_stable_in),
    .pll_reference_clock(pll_reference_clock), .vco_range_code(vco_range_code),
    .loop_filter_setting(loop_filter_setting), .external_osc_enable(external_osc_enable),
    .pll_restart(pll_restart));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // A hung handshake would otherwise stall the run forever.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (pll_reference_clock === 1'b1) pulses <= pulses + 1;
    if (pll_restart === 1'b1) restarts <= restarts + 1;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end

  function automatic logic [7:0] ad(input logic [3:0] i);
    return {2'h0, i, 2'h0};
  endfunction

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Handshakes are judged at the falling edge so that no decision races the design's updates.
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic haw, hw, got;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      haw = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      got = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (haw) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end while (!got);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic hs, got;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      hs = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (hs) s_axi_arvalid <= 1'b0;
    end while (!got);
    s_axi_rready <= 1'b0;
    chk("rdata", ed, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task tog(input int n, input logic rc);
    repeat (n) begin
      repeat (4) @(posedge aclk);
      internal_rc_1mhz <= rc;
      osc_clk_in <= !rc;
      repeat (4) @(posedge aclk);
      internal_rc_1mhz <= 1'b0;
      osc_clk_in <= 1'b0;
    end
    repeat (8) @(negedge aclk);
  endtask

  task t_regs;
    for (int i = 0; i < 6; i++) begin
      if (i != 4) axi_rd(ad(i[3:0]), 32'h0, `RESP_OKAY);
    end
    axi_rd(ad(4'h6), 32'h0, `RESP_SLVERR);
    axi_wr(ad(4'h6), 32'hFF, `RESP_SLVERR);
    axi_wr(ad(`CLOCK_WRITE_PROTECT_IDX), 32'h1, `RESP_OKAY);
    axi_rd(ad(`CLOCK_WRITE_PROTECT_IDX), 32'h1, `RESP_OKAY);
    // A write whose low byte lane is off must leave the register alone.
    s_axi_wstrb <= 4'hE;
    axi_wr(ad(`CLOCK_WRITE_PROTECT_IDX), 32'h0, `RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axi_rd(ad(`CLOCK_WRITE_PROTECT_IDX), 32'h1, `RESP_OKAY);
    $display("t_regs done");
  endtask

  task t_vco;
    logic [1:0] ev;
    for (int c = 0; c < 4; c++) begin
      ev = (c < 2) ? c[1:0] : 2'h1;
      axi_wr(ad(`PLLCFG_IDX), {26'h0, c[1:0], 2'h0, c[1:0]}, `RESP_OKAY);
      axi_rd(ad(`PLLCFG_IDX), {26'h0, c[1:0], 2'h0, ev}, `RESP_OKAY);
      chk("vco_range_code", {30'h0, ev}, {30'h0, vco_range_code});
    end
    $display("t_vco done");
  endtask

  task t_clock_write_protect;
    int r0;
    pll_lock_in <= 1'b1;
    osc_stable_in <= 1'b1;
    repeat (6) @(posedge aclk);
    axi_rd(ad(`STATUS_IDX), 32'h3, `RESP_OKAY);
    r0 = restarts;
    axi_wr(ad(`REFERENCE_DIVIDER_VALUE_IDX), 32'h7, `RESP_OKAY);
    axi_wr(ad(`CLOCK_WRITE_PROTECT_IDX), 32'h0, `RESP_OKAY);
    axi_wr(ad(`REFERENCE_DIVIDER_VALUE_IDX), 32'h7, `RESP_OKAY);
    axi_wr(ad(`CLKSEL_IDX), 32'h1, `RESP_OKAY);
    axi_wr(ad(`CLOCK_WRITE_PROTECT_IDX), 32'h1, `RESP_OKAY);
    axi_wr(ad(`REFERENCE_DIVIDER_VALUE_IDX), 32'h7, `RESP_OKAY);
    axi_rd(ad(`REFERENCE_DIVIDER_VALUE_IDX), 32'h0, `RESP_OKAY);
    axi_rd(ad(`STATUS_IDX), 32'h3, `RESP_OKAY);
    chk("restarts", r0, restarts);
    axi_wr(ad(`CLOCK_WRITE_PROTECT_IDX), 32'h0, `RESP_OKAY);
    axi_wr(ad(`REFERENCE_DIVIDER_VALUE_IDX), 32'h7, `RESP_OKAY);
    axi_rd(ad(`REFERENCE_DIVIDER_VALUE_IDX), 32'h7, `RESP_OKAY);
    axi_rd(ad(`STATUS_IDX), 32'h0, `RESP_OKAY);
    chk("restarts", r0 + 1, restarts);
    $display("t_clock_write_protect done");
  endtask

  task t_ref;
    int p0;
    axi_wr(ad(`PLLCFG_IDX), 32'h20, `RESP_OKAY);
    axi_wr(ad(`CLKSEL_IDX), 32'h3, `RESP_OKAY);
    axi_wr(ad(`REFERENCE_DIVIDER_VALUE_IDX), 32'h2, `RESP_OKAY);
    repeat (4) @(negedge aclk);
    chk("external_osc_enable", 32'h1, {31'h0, external_osc_enable});
    chk("loop_filter_setting", 32'h2, {30'h0, loop_filter_setting});
    p0 = pulses;
    tog(9, 1'b0);
    chk("osc pulses", p0 + 3, pulses);
    axi_wr(ad(`CLKSEL_IDX), 32'h1, `RESP_OKAY);
    repeat (4) @(negedge aclk);
    chk("external_osc_enable", 32'h0, {31'h0, external_osc_enable});
    chk("loop_filter_setting", 32'h0, {30'h0, loop_filter_setting});
    axi_rd(ad(`PLLCFG_IDX), 32'h20, `RESP_OKAY);
    p0 = pulses;
    tog(5, 1'b1);
    chk("rc pulses", p0 + 5, pulses);
    $display("t_ref done");
  endtask

  // With the clock enable low the synchronisers are frozen, so no reference pulse may appear.
  task t_hold;
    int p0;
    p0 = pulses;
    ce <= 1'b0;
    tog(3, 1'b1);
    ce <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("frozen pulses", p0, pulses);
    $display("t_hold done");
  endtask

  task close_out;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, osc_clk_in, internal_rc_1mhz, pll_lock_in, osc_stable_in} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_vco();
    t_clock_write_protect();
    t_ref();
    t_hold();
    close_out();
  end
endmodule
